// ### shared/frt_map.vh
// Register offsets, field positions, reset values and counts of the free running timer.
// Assumes a byte wide register port with a small address and one CPU clock domain.
//
// Functional notes
// - Sixteen bit up counter, free running, seen as high and low byte registers.
// - Internal count tick is the CPU clock divided by 2, 4 or 8.
// - Clock select field both ones takes the count from the external count pin.
// - External clock edge select picks rising or falling pin transitions.
// - All counter updates happen on the CPU clock, external edges included.
// - Writing either counter low byte reloads the counter with FFFCh.
// - Alternate pair reads same count; its low byte never clears overflow.
// - High byte read latches low byte until low byte read, despite repeats.
// - Low byte read outside a pending sequence returns the live low byte.
// - Counter wrap from FFFFh to 0000h sets the overflow flag.
// - Overflow requests interrupt when enabled and CPU mask clear, else pends.
// - Overflow clears after flag register read, then counter low byte access.
// - Runs in WAIT; freezes in HALT, resumes held count or reset count.
// - Active capture edge copies counter into capture register, sets flag.
// - Channel one edge select in control one, channel two in control two.
// - One capture enable covers both channels; interrupt when mask clear.
// - Capture flag clears after flag read, then that channel low byte access.
// - Capture high byte read blocks new transfers until low byte read.
// - Capture register holds the most recent capture, later ones overwrite.
// - With one pulse or PWM active only capture channel two captures.
// - Capture pins feed timer always; absent pins read as one.
`ifndef FRT_MAP_VH
`define FRT_MAP_VH

// ==========================================================
// Register offsets
`define FRT_ADR_CTRL_ONE 4'h0
`define FRT_ADR_CTRL_TWO 4'h1
`define FRT_ADR_FLAGS 4'h2
`define FRT_ADR_CAP1_HI 4'h3
`define FRT_ADR_CAP1_LO 4'h4
`define FRT_ADR_CNT_HI 4'h5
`define FRT_ADR_CNT_LO 4'h6
`define FRT_ADR_ALT_HI 4'h7
`define FRT_ADR_ALT_LO 4'h8
`define FRT_ADR_CAP2_HI 4'h9
`define FRT_ADR_CAP2_LO 4'hA

// ==========================================================
// Control one fields
`define FRT_C1_CAP_IE 7
`define FRT_C1_OVF_IE 5
`define FRT_C1_CAP1_EDGE 1
`define FRT_C1_EXT_EDGE 0
`define FRT_C1_MASK 8'hA3

// ==========================================================
// Control two fields
`define FRT_C2_PWM 7
`define FRT_C2_OPM 4
`define FRT_C2_CLK_HI 3
`define FRT_C2_CLK_LO 2
`define FRT_C2_CAP2_EDGE 1
`define FRT_C2_MASK 8'h9E

// ==========================================================
// Clock select encodings
`define FRT_CLK_DIV4 2'h0
`define FRT_CLK_DIV2 2'h1
`define FRT_CLK_DIV8 2'h2
`define FRT_CLK_EXT 2'h3

// ==========================================================
// Flag register fields
`define FRT_F_CAP1 7
`define FRT_F_CAP2 4
`define FRT_F_OVF 5

// ==========================================================
// Reset values and counts
`define FRT_CNT_RELOAD 16'hFFFC
`define FRT_CNT_TOP 16'hFFFF
`define FRT_WARM_CYCLES 2'h3

`endif

// ### logic/frt_sync.v
// Two stage synchroniser for a group of pin inputs.
// Assumes the pins are asynchronous to clock and idle high.
`timescale 1ns/1ps

module frt_sync #(
   parameter W = 3
) (
   // Clock and reset
   input wire clock,
   input wire rstN,
   // Pins in, synchronised copy out
   input wire [W-1:0] pinIn,
   output wire [W-1:0] pinOut
);

   reg [W-1:0] meta_q;
   reg [W-1:0] sync_q;

   // ==========================================================
   // Reset to ones so an idle high pin gives no edge at release.
   always @(posedge clock or negedge rstN)
   begin
      if (!rstN)
      begin
         meta_q <= {W{1'b1}};
         sync_q <= {W{1'b1}};
      end
      else
      begin
         meta_q <= pinIn;
         sync_q <= meta_q;
      end
   end

   assign pinOut = sync_q;

endmodule

// ### logic/frt_timer.v
// Sixteen bit free running timer with overflow flag and two input capture channels.
// Assumes a CPU driving a byte register port on clock, plus halt and mask levels.
`timescale 1ns/1ps
`include "frt_map.vh"

module frt_timer #(
   parameter ADDR_W = 4,
   parameter CAP_PIN_PRESENT = 2'h3,
   parameter EXT_PIN_PRESENT = 1'b1
) (
   // Clock and reset
   input wire clock,
   input wire nrst,
   // Register port
   input wire [ADDR_W-1:0] regAddr,
   input wire [7:0] regWrData,
   input wire regWr,
   input wire regRd,
   output wire [7:0] regRdData,
   // CPU state
   input wire cpuMask,
   input wire haltMode,
   // Pins
   input wire capturePinOne,
   input wire capturePinTwo,
   input wire externalCountPin,
   // Interrupt request
   output wire timerIrq
);

   // ==========================================================
   // Reset release
   reg [1:0] rstPipe_q;
   wire rstN;

   always @(posedge clock or negedge nrst)
   begin
      if (!nrst)
         rstPipe_q <= 2'h0;
      else
         rstPipe_q <= {rstPipe_q[0], 1'b1};
   end

   assign rstN = rstPipe_q[1];

   // ==========================================================
   // Register decode
   wire wrCtrlOne = regWr && (regAddr == `FRT_ADR_CTRL_ONE);
   wire wrCtrlTwo = regWr && (regAddr == `FRT_ADR_CTRL_TWO);
   wire rdFlags = regRd && (regAddr == `FRT_ADR_FLAGS);
   wire rdCntHi = regRd && (regAddr == `FRT_ADR_CNT_HI);
   wire rdAltHi = regRd && (regAddr == `FRT_ADR_ALT_HI);
   wire rdCntLo = regRd && (regAddr == `FRT_ADR_CNT_LO);
   wire rdAltLo = regRd && (regAddr == `FRT_ADR_ALT_LO);
   wire wrCntLo = regWr && (regAddr == `FRT_ADR_CNT_LO);
   wire wrAltLo = regWr && (regAddr == `FRT_ADR_ALT_LO);
   wire accCntLo = (regRd || regWr) && (regAddr == `FRT_ADR_CNT_LO);
   wire [1:0] rdCapHi;
   wire [1:0] rdCapLo;
   wire [1:0] accCapLo;

   assign rdCapHi[0] = regRd && (regAddr == `FRT_ADR_CAP1_HI);
   assign rdCapHi[1] = regRd && (regAddr == `FRT_ADR_CAP2_HI);
   assign rdCapLo[0] = regRd && (regAddr == `FRT_ADR_CAP1_LO);
   assign rdCapLo[1] = regRd && (regAddr == `FRT_ADR_CAP2_LO);
   assign accCapLo[0] = (regRd || regWr) && (regAddr == `FRT_ADR_CAP1_LO);
   assign accCapLo[1] = (regRd || regWr) && (regAddr == `FRT_ADR_CAP2_LO);

   // ==========================================================
   // Control registers
   reg [7:0] ctrlOne_q;
   reg [7:0] ctrlTwo_q;

   always @(posedge clock or negedge rstN)
   begin
      if (!rstN)
      begin
         ctrlOne_q <= 8'h00;
         ctrlTwo_q <= 8'h00;
      end
      else
      begin
         if (wrCtrlOne)
            ctrlOne_q <= regWrData & `FRT_C1_MASK;
         if (wrCtrlTwo)
            ctrlTwo_q <= regWrData & `FRT_C2_MASK;
      end
   end

   wire [1:0] clockSelectField = ctrlTwo_q[`FRT_C2_CLK_HI:`FRT_C2_CLK_LO];
   wire waveModeActive = ctrlTwo_q[`FRT_C2_OPM] | ctrlTwo_q[`FRT_C2_PWM];
   wire [1:0] captureEdgeSelect;

   assign captureEdgeSelect[0] = ctrlOne_q[`FRT_C1_CAP1_EDGE];
   assign captureEdgeSelect[1] = ctrlTwo_q[`FRT_C2_CAP2_EDGE];

   // ==========================================================
   // Pin synchronisers
   // Pins are read from the pad side even when driven as outputs, so a toggled
   // output still makes captures; a missing pin is tied high and never edges.
   wire [2:0] pinRaw;
   wire [2:0] pinSync;
   reg [2:0] pinPrev_q;
   reg [1:0] warm_q;
   wire warmDone = (warm_q == `FRT_WARM_CYCLES);

   assign pinRaw[0] = CAP_PIN_PRESENT[0] ? capturePinOne : 1'b1;
   assign pinRaw[1] = CAP_PIN_PRESENT[1] ? capturePinTwo : 1'b1;
   assign pinRaw[2] = EXT_PIN_PRESENT ? externalCountPin : 1'b1;

   frt_sync #(
      .W(3)
   ) pinSyncInst (
      .clock(clock),
      .rstN(rstN),
      .pinIn(pinRaw),
      .pinOut(pinSync)
   );

   // Edges are ignored until the synchroniser has settled after reset.
   always @(posedge clock or negedge rstN)
   begin
      if (!rstN)
      begin
         pinPrev_q <= 3'h7;
         warm_q <= 2'h0;
      end
      else
      begin
         pinPrev_q <= pinSync;
         if (!warmDone)
            warm_q <= warm_q + 2'h1;
      end
   end

   wire [2:0] pinRise = pinSync & ~pinPrev_q & {3{warmDone}};
   wire [2:0] pinFall = ~pinSync & pinPrev_q & {3{warmDone}};

   // ==========================================================
   // Prescaler and count tick
   // An external clock faster than half of clock loses edges here.
   reg [2:0] presc_q;
   reg tick;
   wire extEdge;

   assign extEdge = ctrlOne_q[`FRT_C1_EXT_EDGE] ? pinRise[2] : pinFall[2];

   always @(posedge clock or negedge rstN)
   begin
      if (!rstN)
         presc_q <= 3'h0;
      else if (!haltMode)
         presc_q <= presc_q + 3'h1;
   end

   always @*
   begin
      tick = 1'b0;
      case (clockSelectField)
         `FRT_CLK_DIV2: tick = presc_q[0];
         `FRT_CLK_DIV4: tick = (presc_q[1:0] == 2'h3);
         `FRT_CLK_DIV8: tick = (presc_q == 3'h7);
         default: tick = extEdge;
      endcase
   end

   // ==========================================================
   // Free running counter
   reg [15:0] count_q;
   reg [15:0] count_d;
   wire countWrite = wrCntLo | wrAltLo;
   wire countStep = tick & ~haltMode;
   wire countWrap = countStep & ~countWrite & (count_q == `FRT_CNT_TOP);

   always @*
   begin
      count_d = count_q;
      if (countWrite)
         count_d = `FRT_CNT_RELOAD;
      else if (countStep)
         count_d = count_q + 16'h0001;
   end

   always @(posedge clock or negedge rstN)
   begin
      if (!rstN)
         count_q <= `FRT_CNT_RELOAD;
      else
         count_q <= count_d;
   end

   // ==========================================================
   // Two byte counter read latch, shared by the normal and alternate pairs
   reg [7:0] lowLatch_q;
   reg lowPending_q;
   wire rdHiEither = rdCntHi | rdAltHi;
   wire rdLoEither = rdCntLo | rdAltLo;

   always @(posedge clock or negedge rstN)
   begin
      if (!rstN)
      begin
         lowLatch_q <= 8'h00;
         lowPending_q <= 1'b0;
      end
      else if (rdHiEither && !lowPending_q)
      begin
         lowLatch_q <= count_q[7:0];
         lowPending_q <= 1'b1;
      end
      else if (rdLoEither)
         lowPending_q <= 1'b0;
   end

   wire [7:0] countLowView = lowPending_q ? lowLatch_q : count_q[7:0];

   // ==========================================================
   // Overflow flag
   reg overflowFlag_q;
   reg overflowArm_q;

   always @(posedge clock or negedge rstN)
   begin
      if (!rstN)
      begin
         overflowFlag_q <= 1'b0;
         overflowArm_q <= 1'b0;
      end
      else
      begin
         if (countWrap)
            overflowFlag_q <= 1'b1;
         else if (accCntLo && overflowArm_q)
            overflowFlag_q <= 1'b0;
         if (rdFlags)
            overflowArm_q <= overflowFlag_q;
         else if (accCntLo)
            overflowArm_q <= 1'b0;
      end
   end

   // ==========================================================
   // Capture channels
   wire [1:0] captureFlag;
   wire [31:0] captureAll;
   wire [1:0] channelEnable;

   assign channelEnable[0] = ~waveModeActive;
   assign channelEnable[1] = 1'b1;

   genvar ch;
   generate
      for (ch = 0; ch < 2; ch = ch + 1)
      begin : capChan
         reg [15:0] value_q;
         reg flag_q;
         reg arm_q;
         reg hold_q;
         wire hit;

         assign hit = channelEnable[ch] &
            (captureEdgeSelect[ch] ? pinRise[ch] : pinFall[ch]);

         always @(posedge clock or negedge rstN)
         begin
            if (!rstN)
            begin
               value_q <= 16'h0000;
               flag_q <= 1'b0;
               arm_q <= 1'b0;
               hold_q <= 1'b0;
            end
            else
            begin
               if (hit && !hold_q)
                  value_q <= count_q;
               if (hit)
                  flag_q <= 1'b1;
               else if (accCapLo[ch] && arm_q)
                  flag_q <= 1'b0;
               if (rdFlags)
                  arm_q <= flag_q;
               else if (accCapLo[ch])
                  arm_q <= 1'b0;
               if (rdCapHi[ch])
                  hold_q <= 1'b1;
               else if (rdCapLo[ch])
                  hold_q <= 1'b0;
            end
         end

         assign captureFlag[ch] = flag_q;
         assign captureAll[16*ch +: 16] = value_q;
      end
   endgenerate

   // ==========================================================
   // Interrupt request
   reg irq_q;

   always @(posedge clock or negedge rstN)
   begin
      if (!rstN)
         irq_q <= 1'b0;
      else
         irq_q <= ~cpuMask &
            ((overflowFlag_q & ctrlOne_q[`FRT_C1_OVF_IE]) |
             (ctrlOne_q[`FRT_C1_CAP_IE] & (|captureFlag)));
   end

   assign timerIrq = irq_q;

   // ==========================================================
   // Read data, valid only in the cycle after the read strobe
   reg [7:0] rdData_q;
   reg [7:0] rdData_d;
   reg [7:0] flagView;

   always @*
   begin
      flagView = 8'h00;
      flagView[`FRT_F_CAP1] = captureFlag[0];
      flagView[`FRT_F_CAP2] = captureFlag[1];
      flagView[`FRT_F_OVF] = overflowFlag_q;
   end

   always @*
   begin
      rdData_d = 8'h00;
      if (!regRd)
         rdData_d = 8'h00;
      else if (regAddr == `FRT_ADR_CTRL_ONE)
         rdData_d = ctrlOne_q;
      else if (regAddr == `FRT_ADR_CTRL_TWO)
         rdData_d = ctrlTwo_q;
      else if (regAddr == `FRT_ADR_FLAGS)
         rdData_d = flagView;
      else if (regAddr == `FRT_ADR_CAP1_HI)
         rdData_d = captureAll[15:8];
      else if (regAddr == `FRT_ADR_CAP1_LO)
         rdData_d = captureAll[7:0];
      else if ((regAddr == `FRT_ADR_CNT_HI) || (regAddr == `FRT_ADR_ALT_HI))
         rdData_d = count_q[15:8];
      else if ((regAddr == `FRT_ADR_CNT_LO) || (regAddr == `FRT_ADR_ALT_LO))
         rdData_d = countLowView;
      else if (regAddr == `FRT_ADR_CAP2_HI)
         rdData_d = captureAll[31:24];
      else if (regAddr == `FRT_ADR_CAP2_LO)
         rdData_d = captureAll[23:16];
      else
         rdData_d = 8'h00;
   end

   always @(posedge clock or negedge rstN)
   begin
      if (!rstN)
         rdData_q <= 8'h00;
      else
         rdData_q <= rdData_d;
   end

   assign regRdData = rdData_q;

endmodule

// ### verification/frt_timer_sva.sv
// Concurrent checks on the timer register port and interrupt line.
// Assumes one clock domain and the offsets and masks of frt_map.vh.
`timescale 1ns/1ps
`include "frt_map.vh"

module frt_timer_sva #(
   parameter ADDR_W = 4
) (
   // Clock and reset
   input wire clock,
   input wire nrst,
   // Register port
   input wire [ADDR_W-1:0] regAddr,
   input wire [7:0] regWrData,
   input wire regWr,
   input wire regRd,
   input wire [7:0] regRdData,
   // CPU state and interrupt
   input wire cpuMask,
   input wire haltMode,
   input wire timerIrq
);
   // ==========================================================
   // Properties
   default clocking @(posedge clock); endclocking
   default disable iff (!nrst);

   property p_reload;
      regWr && (regAddr == `FRT_ADR_CNT_LO || regAddr == `FRT_ADR_ALT_LO)
      ##2 regRd && regAddr == `FRT_ADR_CNT_HI |=> regRdData == 8'hFF;
   endproperty
   a_reload: assert property (p_reload) else $error("count high byte after reload");

   property p_mask;
      cpuMask |=> !timerIrq;
   endproperty
   a_mask: assert property (p_mask) else $error("interrupt while masked");

   property p_halt;
      haltMode && regRd && regAddr == `FRT_ADR_CNT_HI ##1 haltMode
      ##1 regRd && regAddr == `FRT_ADR_CNT_HI |=> regRdData == $past(regRdData, 2);
   endproperty
   a_halt: assert property (p_halt) else $error("count moved in halt");

   property p_unmapped;
      regRd && regAddr > `FRT_ADR_CAP2_LO |=> regRdData == 8'h00;
   endproperty
   a_unmapped: assert property (p_unmapped) else $error("unmapped read not zero");

   property p_idle;
      !regRd |=> regRdData == 8'h00;
   endproperty
   a_idle: assert property (p_idle) else $error("read data without a read");

   property p_c1;
      regWr && regAddr == `FRT_ADR_CTRL_ONE ##2 regRd && regAddr == `FRT_ADR_CTRL_ONE
      |=> regRdData == ($past(regWrData, 3) & `FRT_C1_MASK);
   endproperty
   a_c1: assert property (p_c1) else $error("control one readback");

   property p_c2;
      regWr && regAddr == `FRT_ADR_CTRL_TWO ##2 regRd && regAddr == `FRT_ADR_CTRL_TWO
      |=> regRdData == ($past(regWrData, 3) & `FRT_C2_MASK);
   endproperty
   a_c2: assert property (p_c2) else $error("control two readback");

   property p_flags;
      regRd && regAddr == `FRT_ADR_FLAGS |=> (regRdData & 8'h4F) == 8'h00;
   endproperty
   a_flags: assert property (p_flags) else $error("flag register spare bits");
endmodule

bind frt_timer frt_timer_sva #(.ADDR_W(ADDR_W)) i_frt_timer_sva (
   .clock(clock), .nrst(nrst), .regAddr(regAddr), .regWrData(regWrData),
   .regWr(regWr), .regRd(regRd), .regRdData(regRdData), .cpuMask(cpuMask),
   .haltMode(haltMode), .timerIrq(timerIrq));

// ### verification/frt_pin_src.sv
// Sources for the capture pins and the external count pin.
// Assumes the bench calls tog from its main process.
`timescale 1ns/1ps

module frt_pin_src (
   // Clock
   input wire clock,
   // Pins
   output logic capOne,
   output logic capTwo,
   output logic extPin
);
   // ==========================================================
   // Pin drive
   // Capture pins rest high, as an absent pin reads.
   initial
   begin
      capOne = 1'b1;
      capTwo = 1'b1;
      extPin = 1'b0;
   end

   // Quiet clocks after each edge keep the count source slow enough.
   task tog(input int k);
      @(posedge clock);
      case (k)
         0: capOne <= ~capOne;
         1: capTwo <= ~capTwo;
         default: extPin <= ~extPin;
      endcase
      repeat (4) @(posedge clock);
   endtask
endmodule

// ### verification/tb_top.sv
// Directed self-checking bench for the free running timer.
// Assumes the timer, the pin sources and the checker bind are compiled first.
`timescale 1ns/1ps
`include "frt_map.vh"

module tb_top;
   logic clock;
   logic nrst;
   logic [3:0] regAddr;
   logic [7:0] regWrData;
   logic regWr;
   logic regRd;
   logic cpuMask;
   logic haltMode;
   wire [7:0] regRdData;
   wire timerIrq, capOne, capTwo, extPin;
   int err_count = 0;
   int check_count = 0;
   int i;
   logic [7:0] ex [3] = '{8'h04, 8'h00, 8'hFE};
   logic [1:0] sl [3] = '{`FRT_CLK_DIV2, `FRT_CLK_DIV4, `FRT_CLK_DIV8};

   always #10 clock = ~clock;

   frt_timer i_frt_timer (.clock(clock), .nrst(nrst), .regAddr(regAddr),
      .regWrData(regWrData), .regWr(regWr), .regRd(regRd), .regRdData(regRdData),
      .cpuMask(cpuMask), .haltMode(haltMode), .capturePinOne(capOne),
      .capturePinTwo(capTwo), .externalCountPin(extPin), .timerIrq(timerIrq));
   frt_pin_src i_frt_pin_src (.clock(clock), .capOne(capOne), .capTwo(capTwo),
      .extPin(extPin));

   // ==========================================================
   // Tasks
   task chk(input string n, input [7:0] e, input [7:0] s);
      check_count++;
      if (s !== e)
      begin
         $display("[ERR] %s expected %h seen %h", n, e, s);
         err_count++;
      end
   endtask

   task wr(input [3:0] a, input [7:0] d);
      @(posedge clock);
      regAddr <= a;
      regWrData <= d;
      regWr <= 1'b1;
      @(posedge clock);
      regWr <= 1'b0;
   endtask

   task rd(input [3:0] a, input [7:0] m, input [7:0] e);
      @(posedge clock);
      regAddr <= a;
      regRd <= 1'b1;
      @(posedge clock);
      regRd <= 1'b0;
      #1;
      chk($sformatf("reg %h", a), e, regRdData & m);
   endtask

   task cyc(input int n);
      repeat (n) @(posedge clock);
   endtask

   task hm(input v);
      @(posedge clock);
      haltMode <= v;
   endtask

   // Sixteen running clocks give an exact step count at any divider phase.
   task run16;
      hm(1'b0);
      cyc(15);
      hm(1'b1);
   endtask

   task ir(input e);
      cyc(2);
      #1;
      chk("irq", {7'h0, e}, {7'h0, timerIrq});
   endtask

   task results;
      $display("checks %0d mismatches %0d", check_count, err_count);
      if (err_count == 0 && check_count > 0)
         $display("NO MISMATCHES");
      else
         $display("MISMATCHES SEEN");
      $finish;
   endtask

   // ==========================================================
   // Tests
   initial
   begin
      clock = 1'b0;
      nrst = 1'b0;
      regAddr = 4'h0;
      regWrData = 8'h00;
      regWr = 1'b0;
      regRd = 1'b0;
      cpuMask = 1'b1;
      haltMode = 1'b0;
      cyc(8);
      nrst <= 1'b1;
      cyc(3);
      rd(`FRT_ADR_CNT_HI, 8'hFF, 8'hFF);
      rd(`FRT_ADR_FLAGS, 8'hFF, 8'h00);
      rd(`FRT_ADR_CTRL_ONE, 8'hFF, 8'h00);
      rd(4'hF, 8'hFF, 8'h00);
      $display("done: reset");
      wr(`FRT_ADR_CTRL_ONE, 8'hFF);
      rd(`FRT_ADR_CTRL_ONE, 8'hFF, `FRT_C1_MASK);
      wr(`FRT_ADR_CTRL_TWO, 8'hFF);
      rd(`FRT_ADR_CTRL_TWO, 8'hFF, `FRT_C2_MASK);
      wr(`FRT_ADR_CTRL_TWO, 8'h04);
      wr(`FRT_ADR_CTRL_ONE, 8'h20);
      wr(`FRT_ADR_CNT_LO, 8'h00);
      rd(`FRT_ADR_CNT_HI, 8'hFF, 8'hFF);
      cyc(20);
      rd(`FRT_ADR_CNT_LO, 8'h00, 8'h00);
      rd(`FRT_ADR_FLAGS, 8'h20, 8'h20);
      rd(`FRT_ADR_ALT_LO, 8'h00, 8'h00);
      rd(`FRT_ADR_FLAGS, 8'h20, 8'h20);
      ir(1'b0);
      @(posedge clock) cpuMask <= 1'b0;
      ir(1'b1);
      rd(`FRT_ADR_CNT_LO, 8'h00, 8'h00);
      ir(1'b0);
      rd(`FRT_ADR_FLAGS, 8'h20, 8'h00);
      wr(`FRT_ADR_CTRL_ONE, 8'h00);
      $display("done: overflow");
      hm(1'b1);
      wr(`FRT_ADR_ALT_LO, 8'h00);
      rd(`FRT_ADR_CNT_LO, 8'hFF, 8'hFC);
      rd(`FRT_ADR_ALT_HI, 8'hFF, 8'hFF);
      hm(1'b0);
      cyc(19);
      hm(1'b1);
      rd(`FRT_ADR_CNT_HI, 8'hFF, 8'h00);
      rd(`FRT_ADR_CNT_HI, 8'hFF, 8'h00);
      rd(`FRT_ADR_CNT_LO, 8'hFF, 8'hFC);
      rd(`FRT_ADR_CNT_LO, 8'hFF, 8'h06);
      $display("done: read sequence");
      for (i = 0; i < 3; i++)
      begin
         wr(`FRT_ADR_CTRL_TWO, {4'h0, sl[i], 2'b00});
         wr(`FRT_ADR_CNT_LO, 8'h00);
         run16;
         rd(`FRT_ADR_CNT_LO, 8'hFF, ex[i]);
      end
      hm(1'b0);
      wr(`FRT_ADR_CTRL_TWO, 8'h0C);
      for (i = 0; i < 2; i++)
      begin
         wr(`FRT_ADR_CTRL_ONE, i == 0 ? 8'h01 : 8'h00);
         wr(`FRT_ADR_CNT_LO, 8'h00);
         repeat (3) i_frt_pin_src.tog(2);
         rd(`FRT_ADR_CNT_LO, 8'hFF, 8'hFE);
      end
      $display("done: clock sources");
      hm(1'b1);
      wr(`FRT_ADR_CTRL_TWO, 8'h00);
      wr(`FRT_ADR_CTRL_ONE, 8'h82);
      wr(`FRT_ADR_CNT_LO, 8'h00);
      i_frt_pin_src.tog(0);
      i_frt_pin_src.tog(0);
      ir(1'b1);
      rd(`FRT_ADR_FLAGS, 8'h90, 8'h80);
      rd(`FRT_ADR_CAP1_HI, 8'hFF, 8'hFF);
      run16;
      i_frt_pin_src.tog(0);
      i_frt_pin_src.tog(0);
      rd(`FRT_ADR_CAP1_LO, 8'hFF, 8'hFC);
      i_frt_pin_src.tog(0);
      i_frt_pin_src.tog(0);
      rd(`FRT_ADR_CAP1_HI, 8'hFF, 8'h00);
      rd(`FRT_ADR_CAP1_LO, 8'hFF, 8'h00);
      rd(`FRT_ADR_FLAGS, 8'h80, 8'h80);
      rd(`FRT_ADR_CAP1_LO, 8'hFF, 8'h00);
      rd(`FRT_ADR_FLAGS, 8'h80, 8'h00);
      ir(1'b0);
      run16;
      i_frt_pin_src.tog(1);
      rd(`FRT_ADR_FLAGS, 8'h90, 8'h10);
      rd(`FRT_ADR_CAP2_HI, 8'hFF, 8'h00);
      rd(`FRT_ADR_CAP2_LO, 8'hFF, 8'h04);
      rd(`FRT_ADR_FLAGS, 8'h10, 8'h00);
      wr(`FRT_ADR_CTRL_TWO, 8'h10);
      i_frt_pin_src.tog(0);
      i_frt_pin_src.tog(0);
      i_frt_pin_src.tog(1);
      i_frt_pin_src.tog(1);
      rd(`FRT_ADR_FLAGS, 8'h90, 8'h10);
      $display("done: capture");
      // A reset taken in HALT must bring back the reset count, not the held one.
      @(posedge clock) nrst <= 1'b0;
      cyc(2);
      nrst <= 1'b1;
      cyc(3);
      rd(`FRT_ADR_CNT_HI, 8'hFF, 8'hFF);
      rd(`FRT_ADR_CNT_LO, 8'hFF, 8'hFC);
      rd(`FRT_ADR_FLAGS, 8'hFF, 8'h00);
      $display("done: second reset");
      results;
   end

   initial
   begin
      cyc(5000);
      err_count++;
      results;
   end
endmodule
